/* File: verilog/cgl_clock_gen.v */
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "cgl_consts.vh"

// Notes on behaviour
// [R1] The bus clock runs at a quarter of the oscillator output clock and half the generator output clock.
// [R2] In stop mode the generator stop signal is raised and all internal, external and base clocks are forced low.
// [R3] The internal enable is the internal-on bit and not stop, and while it is low the internal and base clocks are low.
// [R4] The external enable is the external-on bit and not stop, and while it is low the external clock is low.
// [R5] The internal clock is N times the base clock, with N from the multiplier register.
// [R6] The oscillator word is a 4-bit divider field above an 8-bit stage field, valid from 0x000 to 0x9ff.
// [R7] The base clock is the internal clock divided by N, undivided when N is 0x00 or 0x01.
// [R8] The loop filter works on the whole 12-bit word so stage carries and borrows move the divider field.
// [R9] Each error band steps the word by -32, -8, -1, +1, +8 or +32 from slowest to fastest base clock.
// [R10] A divider field of 0xa to 0xf is presented to the oscillator as 0x9.
// [R11] An out-of-range word recovers only through ordinary steps and may settle there.
// [R12] The filter-stable flag is set while the base clock error is within five percent.
// [R13] The filter makes one step per base clock period and holds the word in between.
module cgl_clock_gen (
    input wire pclk,
    input wire presetn,
    input wire [11:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire stop_mode,
    input wire ring_osc_in,
    input wire ext_clk_pin,
    input wire [2:0] cmp_band,
    output reg internal_clock,
    output reg external_clock,
    output wire base_clock,
    output reg oscillator_output_clock,
    output reg generator_output_clock,
    output reg bus_clock,
    output reg generator_stop,
    output reg internal_gen_enable,
    output reg external_gen_enable,
    output reg [7:0] stage_control_field,
    output reg [3:0] divider_control_field,
    output reg filter_stable_flag,
    output reg irq
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [4:0] sync1_reg;
    reg [4:0] sync2_reg;
    reg [`CGL_CTRL_W-1:0] ctrl_reg;
    reg [`CGL_MULT_W-1:0] mult_reg;
    reg [`CGL_WORD_W-1:0] word_reg;
    reg [`CGL_WORD_W-1:0] word_next;
    reg [`CGL_IRQ_W-1:0] istat_reg;
    reg [`CGL_IRQ_W-1:0] imask_reg;
    reg [`CGL_IRQ_W-1:0] istat_next;
    reg [`CGL_IRQ_W-1:0] ev_next;
    reg base_prev_reg;
    reg stable_next;
    reg [31:0] rdata_next;
    reg err_next;
    wire ring_s;
    wire ext_s;
    wire [2:0] band_s;
    wire int_en_next;
    wire ext_en_next;
    wire internal_clock_next;
    wire external_clock_next;
    wire osc_next;
    wire gen_next;
    wire bus_next;
    wire internal_clock_rise;
    wire eval;
    wire setup_phase;
    wire wr_fire;
    wire [3:0] div_raw;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Ring oscillator, crystal pin and comparator are all asynchronous to pclk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {cmp_band, ext_clk_pin, ring_osc_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign ring_s = sync2_reg[0];
    assign ext_s = sync2_reg[1];
    assign band_s = sync2_reg[4:2];

    // ----------------------------------------
    // Clock enable circuit
    // ----------------------------------------
    assign int_en_next = ctrl_reg[`CGL_CTRL_INT_ON] & ~stop_mode; // R3
    assign ext_en_next = ctrl_reg[`CGL_CTRL_EXT_ON] & ~stop_mode; // R4
    // Gating by the enable also forces the internal and external clocks low in stop mode
    assign internal_clock_next = ring_s & int_en_next; // R2 R3
    assign external_clock_next = ext_s & ext_en_next; // R2 R4
    assign internal_clock_rise = internal_clock_next & ~internal_clock;

    // Source choice is a plain control bit; glitch-free switching is not modelled
    assign osc_next = ctrl_reg[`CGL_CTRL_SEL_EXT] ? external_clock_next : internal_clock_next;
    // Toggle dividers: generator clock is half, bus clock a quarter of the oscillator output
    assign gen_next = (osc_next & ~oscillator_output_clock) ? ~generator_output_clock : generator_output_clock; // R1
    assign bus_next = (gen_next & ~generator_output_clock) ? ~bus_clock : bus_clock; // R1

    // Enables and clock outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            generator_stop <= 1'b0;
            internal_gen_enable <= 1'b0;
            external_gen_enable <= 1'b0;
            internal_clock <= 1'b0;
            external_clock <= 1'b0;
            oscillator_output_clock <= 1'b0;
            generator_output_clock <= 1'b0;
            bus_clock <= 1'b0;
        end else begin
            generator_stop <= stop_mode; // R2
            internal_gen_enable <= int_en_next; // R3
            external_gen_enable <= ext_en_next; // R4
            internal_clock <= internal_clock_next;
            external_clock <= external_clock_next;
            oscillator_output_clock <= osc_next;
            generator_output_clock <= gen_next; // R1
            bus_clock <= bus_next; // R1
        end
    end

    // ----------------------------------------
    // Modulo-N divider
    // ----------------------------------------
    cgl_modn_div #(
        .N_W(`CGL_MULT_W)
    ) u_modn_div (
        .pclk(pclk),
        .presetn(presetn),
        .enable(int_en_next),
        .internal_clock_level(internal_clock_next),
        .internal_clock_rise(internal_clock_rise),
        .n_factor(mult_reg),
        .base_clock(base_clock)
    );

    // ----------------------------------------
    // Digital loop filter
    // ----------------------------------------
    // One evaluation per base clock period, on its rising edge
    assign eval = base_clock & ~base_prev_reg; // R13

    // Whole-word arithmetic lets stage carries and borrows reach the divider field
    always @* begin
        word_next = word_reg; // R13
        if (eval) begin
            case (band_s)
                `CGL_BAND_BELOW_085: word_next = word_reg - `CGL_STEP_COARSE; // R9 R8
                `CGL_BAND_085_095: word_next = word_reg - `CGL_STEP_MID; // R9
                `CGL_BAND_095_100: word_next = word_reg - `CGL_STEP_FINE; // R9
                `CGL_BAND_100_105: word_next = word_reg + `CGL_STEP_FINE; // R9
                `CGL_BAND_105_115: word_next = word_reg + `CGL_STEP_MID; // R9
                `CGL_BAND_ABOVE_115: word_next = word_reg + `CGL_STEP_COARSE; // R9 R8
                default: word_next = word_reg;
            endcase
        end
    end

    // Stable flag follows the latest evaluation; idle generator is not stable
    always @* begin
        stable_next = filter_stable_flag;
        if (!int_en_next) begin
            stable_next = 1'b0;
        end else if (eval) begin
            stable_next = (band_s == `CGL_BAND_095_100) || (band_s == `CGL_BAND_100_105); // R12
        end
    end

    // Divider field wraps freely; no special recovery path exists
    assign div_raw = word_next[11:8]; // R11

    // Word and oscillator control outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_reg <= `CGL_WORD_RESET;
            base_prev_reg <= 1'b0;
            filter_stable_flag <= 1'b0;
            stage_control_field <= 8'h00;
            divider_control_field <= 4'h0;
        end else begin
            word_reg <= word_next; // R8 R11
            base_prev_reg <= base_clock;
            filter_stable_flag <= stable_next; // R12
            stage_control_field <= word_next[7:0]; // R6
            divider_control_field <= (div_raw > `CGL_DIV_SLOWEST) ? `CGL_DIV_SLOWEST : div_raw; // R10 R6
        end
    end

    // ----------------------------------------
    // Interrupt events
    // ----------------------------------------
    always @* begin
        ev_next = {`CGL_IRQ_W{1'b0}};
        ev_next[`CGL_IRQ_STABLE_SET] = stable_next & ~filter_stable_flag;
        ev_next[`CGL_IRQ_STABLE_LOST] = ~stable_next & filter_stable_flag;
        ev_next[`CGL_IRQ_RANGE] = eval & (word_next > `CGL_WORD_MAX);
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Answer is prepared in the setup cycle so pready is high in the first access cycle
    assign setup_phase = psel & ~penable;
    assign wr_fire = psel & penable & pready & pwrite;

    always @* begin
        rdata_next = 32'h00000000;
        err_next = 1'b0;
        case (paddr)
            `CGL_ADDR_CTRL: rdata_next[`CGL_CTRL_W-1:0] = ctrl_reg;
            `CGL_ADDR_MULT: rdata_next[`CGL_MULT_W-1:0] = mult_reg;
            `CGL_ADDR_WORD: begin
                rdata_next[`CGL_WORD_W-1:0] = word_reg;
                rdata_next[`CGL_WORD_STABLE] = filter_stable_flag;
                rdata_next[`CGL_WORD_INT_EN] = internal_gen_enable;
                rdata_next[`CGL_WORD_EXT_EN] = external_gen_enable;
                rdata_next[`CGL_WORD_STOP] = generator_stop;
            end
            `CGL_ADDR_ISTAT: rdata_next[`CGL_IRQ_W-1:0] = istat_reg;
            `CGL_ADDR_IMASK: rdata_next[`CGL_IRQ_W-1:0] = imask_reg;
            default: err_next = 1'b1;
        endcase
        if (pwrite) begin
            rdata_next = 32'h00000000;
        end
    end

    // Sticky status: a new event wins over a write-one clear in the same cycle
    always @* begin
        istat_next = istat_reg;
        if (wr_fire && (paddr == `CGL_ADDR_ISTAT)) begin
            istat_next = istat_next & ~pwdata[`CGL_IRQ_W-1:0];
        end
        istat_next = istat_next | ev_next;
    end

    // Bus handshake, registers and interrupt line
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl_reg <= `CGL_CTRL_RESET;
            mult_reg <= `CGL_MULT_RESET;
            istat_reg <= {`CGL_IRQ_W{1'b0}};
            imask_reg <= {`CGL_IRQ_W{1'b0}};
            irq <= 1'b0;
        end else begin
            pready <= setup_phase;
            pslverr <= setup_phase & err_next;
            prdata <= setup_phase ? rdata_next : 32'h00000000;
            if (wr_fire && (paddr == `CGL_ADDR_CTRL)) begin
                ctrl_reg <= pwdata[`CGL_CTRL_W-1:0];
            end
            if (wr_fire && (paddr == `CGL_ADDR_MULT)) begin
                mult_reg <= pwdata[`CGL_MULT_W-1:0]; // R5
            end
            if (wr_fire && (paddr == `CGL_ADDR_IMASK)) begin
                imask_reg <= pwdata[`CGL_IRQ_W-1:0];
            end
            istat_reg <= istat_next;
            irq <= |(istat_next & imask_reg);
        end
    end

endmodule

/* File: verilog/cgl_consts.vh */
`ifndef CGL_CONSTS_VH
`define CGL_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CGL_ADDR_CTRL 12'h000
`define CGL_ADDR_MULT 12'h004
`define CGL_ADDR_WORD 12'h008
`define CGL_ADDR_ISTAT 12'h00c
`define CGL_ADDR_IMASK 12'h010

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CGL_CTRL_INT_ON 0
`define CGL_CTRL_EXT_ON 1
`define CGL_CTRL_SEL_EXT 2
`define CGL_CTRL_W 3
`define CGL_CTRL_RESET 3'h1

// ----------------------------------------
// Multiplier and control word
// ----------------------------------------
`define CGL_MULT_W 8
`define CGL_MULT_RESET 8'h01
`define CGL_WORD_W 12
`define CGL_WORD_RESET 12'h000
`define CGL_WORD_MAX 12'h9ff
`define CGL_DIV_SLOWEST 4'h9
`define CGL_STEP_FINE 12'h001
`define CGL_STEP_MID 12'h008
`define CGL_STEP_COARSE 12'h020

// ----------------------------------------
// Comparator band codes (base clock vs nominal)
// ----------------------------------------
`define CGL_BAND_BELOW_085 3'h0
`define CGL_BAND_085_095 3'h1
`define CGL_BAND_095_100 3'h2
`define CGL_BAND_100_105 3'h3
`define CGL_BAND_105_115 3'h4
`define CGL_BAND_ABOVE_115 3'h5

// ----------------------------------------
// Status word read layout
// ----------------------------------------
`define CGL_WORD_STABLE 12
`define CGL_WORD_INT_EN 13
`define CGL_WORD_EXT_EN 14
`define CGL_WORD_STOP 15

// ----------------------------------------
// Interrupt status and mask bits
// ----------------------------------------
`define CGL_IRQ_STABLE_SET 0
`define CGL_IRQ_STABLE_LOST 1
`define CGL_IRQ_RANGE 2
`define CGL_IRQ_W 3

`endif

/* File: verilog/cgl_modn_div.v */
`timescale 1ns/1ns

// ----------------------------------------
// Modulo-N divider: base clock from internal clock
// ----------------------------------------
module cgl_modn_div #(
    parameter N_W = 8
) (
    input wire pclk,
    input wire presetn,
    input wire enable,
    input wire internal_clock_level,
    input wire internal_clock_rise,
    input wire [N_W-1:0] n_factor,
    output reg base_clock
);

    reg [N_W-1:0] cnt_reg;
    reg [N_W-1:0] cnt_next;
    reg base_next;
    wire bypass;
    wire [N_W-1:0] n_last;
    wire [N_W-1:0] n_half;

    // N of 0 or 1 passes the internal clock straight through
    assign bypass = (n_factor <= {{(N_W-1){1'b0}}, 1'b1});
    assign n_last = n_factor - {{(N_W-1){1'b0}}, 1'b1};
    assign n_half = n_factor >> 1;

    // Count internal clock edges; low for the first half of each N-cycle.
    // Starting low means a divider restart by the enable (a new N keeps the count) never raises the
    // base clock without an internal clock edge, so no loop step is faked
    always @* begin
        cnt_next = cnt_reg;
        base_next = 1'b0;
        if (!enable) begin
            cnt_next = {N_W{1'b0}};
            base_next = 1'b0;
        end else if (bypass) begin
            cnt_next = {N_W{1'b0}};
            base_next = internal_clock_level; // R7
        end else begin
            if (internal_clock_rise) begin
                cnt_next = (cnt_reg >= n_last) ? {N_W{1'b0}} : cnt_reg + {{(N_W-1){1'b0}}, 1'b1}; // R5 R7
            end
            base_next = (cnt_next >= n_half); // R7
        end
    end

    // Divider state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= {N_W{1'b0}};
            base_clock <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            base_clock <= base_next; // R3
        end
    end

endmodule

/* File: testbench/cgl_clock_gen_monitor.sv */
`timescale 1ns/1ns

// ----------------------------------------
// Port checker for the clock generator
// ----------------------------------------
module cgl_clock_gen_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire stop_mode,
    input wire internal_clock,
    input wire external_clock,
    input wire base_clock,
    input wire generator_stop,
    input wire internal_gen_enable,
    input wire external_gen_enable,
    input wire [7:0] stage_control_field,
    input wire [3:0] divider_control_field,
    input wire filter_stable_flag
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Clock gating by stop mode and by the enables
    a_stop_all_low: assert property (stop_mode |=> generator_stop && !internal_clock && !external_clock)
        else $error("clocks still running in stop mode");
    a_stop_enables: assert property (stop_mode |=> !internal_gen_enable && !external_gen_enable)
        else $error("enable still set in stop mode");
    a_int_gated: assert property (!internal_gen_enable |-> !internal_clock)
        else $error("internal clock high while disabled");
    // Base clock falls on the same edge as the enable; checked here only after two low cycles
    a_base_gated: assert property (!internal_gen_enable [*2] |-> !base_clock)
        else $error("base clock high while disabled");
    a_ext_gated: assert property (!external_gen_enable |-> !external_clock)
        else $error("external clock high while disabled");
    a_div_clamp: assert property (divider_control_field <= 4'h9)
        else $error("divider field above slowest setting");
    // The word moves only on the edge after a base clock rise
    a_word_hold: assert property (!($past(base_clock) && !$past(base_clock, 2))
        |-> $stable({divider_control_field, stage_control_field}))
        else $error("control word moved between evaluations");
    a_flag_on_step: assert property ($changed(filter_stable_flag) |-> ($past(base_clock) && !$past(base_clock, 2))
        || !internal_gen_enable || !$past(internal_gen_enable))
        else $error("stable flag changed outside an evaluation");
    // Zero wait state bus answer, one cycle wide
    a_ready_follows: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
endmodule

bind cgl_clock_gen cgl_clock_gen_monitor cgl_clock_gen_monitor_i (.pclk, .presetn, .psel, .penable, .pready,
    .stop_mode, .internal_clock, .external_clock, .base_clock, .generator_stop, .internal_gen_enable,
    .external_gen_enable, .stage_control_field, .divider_control_field, .filter_stable_flag);

/* File: testbench/cgl_sys_model.sv */
`timescale 1ns/1ns

// ----------------------------------------
// Downstream clock consumer model
// ----------------------------------------
// Counts rising edges by sampling on pclk; valid only while the
// observed clocks stay below half the pclk rate
module cgl_sys_model (
    input wire pclk,
    input wire clr,
    input wire osc,
    input wire gen,
    input wire bus,
    input wire base,
    output reg [31:0] cnt_reg
);
    reg [3:0] prev_reg;
    wire [3:0] lvl;
    integer i;

    // Observed levels gathered so each lane can be indexed
    assign lvl = {osc, gen, bus, base};

    // Byte lanes: osc, gen, bus, base from high to low
    always @(posedge pclk) begin
        prev_reg <= lvl;
        for (i = 0; i < 4; i = i + 1) begin
            if (clr) begin
                cnt_reg[i*8 +: 8] <= 8'h00;
            end else begin
                cnt_reg[i*8 +: 8] <= cnt_reg[i*8 +: 8] + {7'h00, lvl[i] & ~prev_reg[i]};
            end
        end
    end
endmodule

/* File: testbench/tb.sv */
`timescale 1ns/1ns
`include "cgl_consts.vh"

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stop_mode = 1'b0, ring = 1'b0, clr = 1'b0, er;
    logic [31:0] pwdata = 32'h0, prdata, rd, cnt;
    logic [2:0] band = 3'h6;
    logic pready, pslverr, internal_clock, external_clock, base_clock, oscillator_output_clock;
    logic generator_output_clock, bus_clock, generator_stop, internal_gen_enable, external_gen_enable;
    logic filter_stable_flag, irq;
    logic [7:0] stage_control_field;
    logic [3:0] divider_control_field;
    logic [2:0] bt [0:6] = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
    logic [11:0] wt [0:6] = '{12'h001, 12'h021, 12'h029, 12'h028, 12'h020, 12'h000, 12'hfe0};
    int err_total = 0;
    int n_checks = 0;

    cgl_clock_gen cgl_clock_gen_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .stop_mode, .ring_osc_in(ring), .ext_clk_pin(ring), .cmp_band(band),
        .internal_clock, .external_clock, .base_clock, .oscillator_output_clock, .generator_output_clock,
        .bus_clock, .generator_stop, .internal_gen_enable, .external_gen_enable, .stage_control_field,
        .divider_control_field, .filter_stable_flag, .irq);
    cgl_sys_model cgl_sys_model_i (.pclk, .clr, .osc(oscillator_output_clock), .gen(generator_output_clock),
        .bus(bus_clock), .base(base_clock), .cnt_reg(cnt));

    initial forever #5 pclk = ~pclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Setup then access; wait for pready, take data at that edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 20) begin
            k++;
            @(posedge pclk);
        end
        if (k == 20) err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Ring and pin pulse 4 high 4 low; ring rests low so the loop holds
    task pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            ring <= 1'b1;
            repeat (4) @(posedge pclk);
            ring <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        repeat (12) @(posedge pclk);
    endtask

    task count(input int n);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        pulse(n);
    endtask

    // One evaluation with a given band, then the word and flag
    task step(input logic [2:0] b, input logic [11:0] e);
        band <= b;
        pulse(1);
        chk("word_out", {20'h0, (e[11:8] > 4'h9) ? 4'h9 : e[11:8], e[7:0]},
            {20'h0, divider_control_field, stage_control_field});
        chk("stable", {31'h0, b == 3'h2 || b == 3'h3}, {31'h0, filter_stable_flag});
    endtask

    task final_report();
        if (err_total == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CGL_ADDR_CTRL, 32'h0);
        chk("ctrl_rst", 32'h1, rd);
        apb(1'b0, `CGL_ADDR_MULT, 32'h0);
        chk("mult_rst", 32'h1, rd);
        apb(1'b0, `CGL_ADDR_WORD, 32'h0);
        chk("word_rst", 32'h2000, rd);
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        chk("unmapped_data", 32'h0, rd);
        for (int i = 0; i < 7; i++) step(bt[i], wt[i]);
        apb(1'b0, `CGL_ADDR_WORD, 32'h0);
        chk("word_wrap", 32'hfe0, rd & 32'hfff);
        apb(1'b0, `CGL_ADDR_ISTAT, 32'h0);
        chk("istat", 32'h7, rd);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, `CGL_ADDR_IMASK, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, `CGL_ADDR_ISTAT, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq_off", 32'h0, {31'h0, irq});
        apb(1'b0, `CGL_ADDR_ISTAT, 32'h0);
        chk("istat_w1c", 32'h3, rd);
        // Out of range recovers by 48 plain subtractions
        repeat (48) pulse(1);
        apb(1'b0, `CGL_ADDR_WORD, 32'h0);
        chk("word_recover", 32'h9e0, rd & 32'hfff);
        step(3'h5, 12'ha00);
        apb(1'b0, `CGL_ADDR_WORD, 32'h0);
        chk("word_carry", 32'ha00, rd & 32'hfff);
        band <= 3'h6;
        apb(1'b1, `CGL_ADDR_MULT, 32'h4);
        count(16);
        chk("div4", 32'h10080404, cnt);
        apb(1'b1, `CGL_ADDR_MULT, 32'h0);
        count(16);
        chk("div0", 32'h10080410, cnt);
        apb(1'b1, `CGL_ADDR_CTRL, 32'h7);
        count(16);
        chk("ext_sel", 32'h10080410, cnt);
        stop_mode <= 1'b1;
        count(8);
        chk("stopped", 32'h0, cnt);
        chk("stop_out", 32'h4, {29'h0, generator_stop, internal_gen_enable, external_gen_enable});
        apb(1'b0, `CGL_ADDR_WORD, 32'h0);
        chk("word_stop", 32'h8000, rd & 32'he000);
        stop_mode <= 1'b0;
        apb(1'b1, `CGL_ADDR_CTRL, 32'h0);
        count(8);
        chk("gen_off", 32'h0, cnt);
        chk("en_off", 32'h0, {30'h0, internal_gen_enable, external_gen_enable});
        final_report();
    end
endmodule
